/* File: stl_host_ctrl.sv */
// Purpose: host controller model driving the two external-limit contacts
// Assumes: the device samples the contacts on the same clock
// Notes: requests are active high here, the contacts themselves active low
`timescale 1ns/100ps
module stl_host_ctrl (
	input wire logic clk,
	input wire logic fwd_req,
	input wire logic rev_req,
	output logic fwd_limit_n,
	output logic rev_limit_n
);
	// ----------------------------------------------------------------
	// contact drive
	// ----------------------------------------------------------------
	// contacts start open so no limit is requested out of reset
	initial begin
		fwd_limit_n = 1'h1;
		rev_limit_n = 1'h1;
	end
	// contact pulled low to request the limit, held high for normal run
	always @(posedge clk) begin
		fwd_limit_n <= ~fwd_req;
		rev_limit_n <= ~rev_req;
	end
endmodule

/* File: stl_limit_cmp.sv */
// Purpose: picks the active limit for one direction and compares the reference
// Assumes: limits already clamped to the legal range
// Notes: pure combinational
`timescale 1ns/100ps
module stl_limit_cmp
	import stl_pkg::*;
(
	input wire stl_pct_t INT_LIMIT,
	input wire stl_pct_t EXT_LIMIT,
	input wire logic EXT_ACTIVE,
	input wire stl_pct_t MAGNITUDE,
	output stl_pct_t ACTIVE_LIMIT,
	output logic OVER
);
	// smaller of internal and requested external limit
	always_comb begin
		if (EXT_ACTIVE && (EXT_LIMIT < INT_LIMIT)) begin
			ACTIVE_LIMIT = EXT_LIMIT;
		end else begin
			ACTIVE_LIMIT = INT_LIMIT;
		end
		OVER = (MAGNITUDE > ACTIVE_LIMIT);
	end
endmodule

/* File: stl_map.svh */
// Purpose: offsets, field positions, reset values and limits of the torque-limit supervisor
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes: torque values are percent of rated torque
`ifndef STL_MAP_SVH
`define STL_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define STL_FWD_INT_OFS 8'h00
`define STL_REV_INT_OFS 8'h04
`define STL_FWD_EXT_OFS 8'h08
`define STL_REV_EXT_OFS 8'h0c
`define STL_OUT_SEL_OFS 8'h10
`define STL_OUT_OTHER_OFS 8'h14
`define STL_TORQUE_OFS 8'h18
`define STL_STATUS_OFS 8'h1c
`define STL_IRQ_STAT_OFS 8'h20
`define STL_IRQ_MASK_OFS 8'h24
`define STL_IN_MON_OFS 8'h28
`define STL_OUT_MON_OFS 8'h2c

// ----------------------------------------------------------------
// reset values and ranges
// ----------------------------------------------------------------
`define STL_INT_LIMIT_RST 16'h0320
`define STL_EXT_LIMIT_RST 16'h0064
`define STL_OUT_SEL_RST 16'h0000
`define STL_LIMIT_MAX 16'h0320

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define STL_SEL_LSB 0
`define STL_SEL_MSB 3
`define STL_MON_FWD_BIT 6
`define STL_MON_REV_BIT 7
`define STL_IRQ_SET_BIT 0
`define STL_IRQ_CLR_BIT 1

`endif

/* File: stl_pkg.sv */
// Purpose: types shared by the torque-limit supervisor
// Assumes: nothing
// Notes: none
package stl_pkg;
	typedef logic [15:0] stl_pct_t;
	typedef enum logic [1:0] {STL_WR_IDLE, STL_WR_RESP} stl_wr_state_t;
endpackage

/* File: stl_torque_limit.sv */
// Purpose: torque-limit supervisor with AXI4-Lite registers
// Assumes: torque reference is a signed percent of rated torque, on CLK
// Notes: limited-flag contact is active low, routed to one of three circuits
`timescale 1ns/100ps
`include "stl_map.svh"
module stl_torque_limit
	import stl_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic signed [15:0] TORQUE_REF,
	input wire logic FWD_EXT_LIMIT_IN_N,
	input wire logic REV_EXT_LIMIT_IN_N,
	input wire logic [7:0] INPUT_PINS,
	output logic [2:0] OUT_CIRCUIT_N,
	output logic TORQUE_LIMITED_FLAG,
	output logic IRQ,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	stl_pct_t fwd_internal_limit_ff;
	stl_pct_t rev_internal_limit_ff;
	stl_pct_t fwd_external_limit_ff;
	stl_pct_t rev_external_limit_ff;
	logic [15:0] output_select_two_ff;
	logic [2:0] other_out_ff;
	logic [1:0] irq_stat_ff;
	logic [1:0] irq_mask_ff;
	logic [9:0] pin_meta_ff;
	logic [9:0] pin_sync_ff;
	logic flag_ff;
	logic [2:0] circ_n_ff;
	logic aw_got_ff;
	logic w_got_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic fwd_ext_active;
	logic rev_ext_active;
	stl_pct_t magnitude;
	logic is_reverse;
	stl_pct_t fwd_active;
	stl_pct_t rev_active;
	logic fwd_over;
	logic rev_over;
	logic nxt_flag;
	logic [2:0] nxt_circ;
	logic [1:0] irq_evt;
	logic wr_fire;
	logic [31:0] wr_val;
	logic wr_ok;
	logic [31:0] rd_val;
	logic rd_ok;
	logic [3:0] sel_field;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// two flops on every pin before logic reads it
	always_ff @(posedge CLK) begin
		if (RST) begin
			pin_meta_ff <= 10'h3ff;
			pin_sync_ff <= 10'h3ff;
		end else begin
			pin_meta_ff <= {REV_EXT_LIMIT_IN_N, FWD_EXT_LIMIT_IN_N, INPUT_PINS};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// active-low contact inputs
	assign fwd_ext_active = ~pin_sync_ff[8];
	assign rev_ext_active = ~pin_sync_ff[9];

	// ----------------------------------------------------------------
	// limit comparison, one per direction
	// ----------------------------------------------------------------
	// magnitude in percent of rated torque
	assign is_reverse = TORQUE_REF[15];
	assign magnitude = is_reverse ? 16'(-TORQUE_REF) : 16'(TORQUE_REF);

	stl_limit_cmp u_fwd_cmp (
		.INT_LIMIT(fwd_internal_limit_ff),
		.EXT_LIMIT(fwd_external_limit_ff),
		.EXT_ACTIVE(fwd_ext_active),
		.MAGNITUDE(magnitude),
		.ACTIVE_LIMIT(fwd_active),
		.OVER(fwd_over)
	);

	stl_limit_cmp u_rev_cmp (
		.INT_LIMIT(rev_internal_limit_ff),
		.EXT_LIMIT(rev_external_limit_ff),
		.EXT_ACTIVE(rev_ext_active),
		.MAGNITUDE(magnitude),
		.ACTIVE_LIMIT(rev_active),
		.OVER(rev_over)
	);

	// each direction is judged only against its own limit
	assign nxt_flag = is_reverse ? rev_over : fwd_over;

	// ----------------------------------------------------------------
	// output routing
	// ----------------------------------------------------------------
	assign sel_field = output_select_two_ff[`STL_SEL_MSB:`STL_SEL_LSB];

	// per circuit: or of the flag (if routed there) and other mapped signals
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_circ
			assign nxt_circ[gi] = (nxt_flag && (sel_field == 4'(gi + 1)))
				|| other_out_ff[gi];
		end
	endgenerate

	// contacts close (drive low) while their circuit is on
	always_ff @(posedge CLK) begin
		if (RST) begin
			flag_ff <= 1'b0;
			circ_n_ff <= 3'h7;
		end else begin
			flag_ff <= nxt_flag;
			circ_n_ff <= ~nxt_circ;
		end
	end

	assign TORQUE_LIMITED_FLAG = flag_ff;
	assign OUT_CIRCUIT_N = circ_n_ff;

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// bit 0 on flag rising, bit 1 on flag falling
	assign irq_evt = {flag_ff & ~nxt_flag, ~flag_ff & nxt_flag};

	// sticky status, write one to clear, set wins
	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_stat_ff <= 2'h0;
		end else if (wr_fire && aw_addr_ff == `STL_IRQ_STAT_OFS && w_strb_ff[0]) begin
			irq_stat_ff <= (irq_stat_ff & ~w_data_ff[1:0]) | irq_evt;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_evt;
		end
	end

	assign IRQ = |(irq_stat_ff & irq_mask_ff);

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	// address and data are latched independently, in either order
	always_ff @(posedge CLK) begin
		if (RST) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_got_ff <= 1'b1;
				aw_addr_ff <= S_AXI_AWADDR[7:0];
			end else if (wr_fire) begin
				aw_got_ff <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_got_ff <= 1'b1;
				w_data_ff <= S_AXI_WDATA;
				w_strb_ff <= S_AXI_WSTRB;
			end else if (wr_fire) begin
				w_got_ff <= 1'b0;
			end
		end
	end

	assign S_AXI_AWREADY = ~aw_got_ff & ~bvalid_ff;
	assign S_AXI_WREADY = ~w_got_ff & ~bvalid_ff;
	assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;

	// byte-lane merge of the low halfword
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// clamp percent values to the legal range
	function automatic logic [15:0] clamp_pct(input logic [15:0] v);
		clamp_pct = (v > `STL_LIMIT_MAX) ? `STL_LIMIT_MAX : v;
	endfunction

	// decode write and compute slave error for unmapped offsets
	always_comb begin
		wr_ok = 1'b1;
		wr_val = 32'h0;
		unique case (aw_addr_ff)
			`STL_FWD_INT_OFS: wr_val = 32'(merge16(fwd_internal_limit_ff, w_data_ff, w_strb_ff));
			`STL_REV_INT_OFS: wr_val = 32'(merge16(rev_internal_limit_ff, w_data_ff, w_strb_ff));
			`STL_FWD_EXT_OFS: wr_val = 32'(merge16(fwd_external_limit_ff, w_data_ff, w_strb_ff));
			`STL_REV_EXT_OFS: wr_val = 32'(merge16(rev_external_limit_ff, w_data_ff, w_strb_ff));
			`STL_OUT_SEL_OFS: wr_val = 32'(merge16(output_select_two_ff, w_data_ff, w_strb_ff));
			`STL_OUT_OTHER_OFS: wr_val = {29'h0, w_strb_ff[0] ? w_data_ff[2:0] : other_out_ff};
			`STL_IRQ_MASK_OFS: wr_val = {30'h0, w_strb_ff[0] ? w_data_ff[1:0] : irq_mask_ff};
			`STL_IRQ_STAT_OFS, `STL_TORQUE_OFS, `STL_STATUS_OFS,
			`STL_IN_MON_OFS, `STL_OUT_MON_OFS: wr_val = 32'h0;
			default: wr_ok = 1'b0;
		endcase
	end

	// limit registers: internal reset 800, external reset 100
	always_ff @(posedge CLK) begin
		if (RST) begin
			fwd_internal_limit_ff <= `STL_INT_LIMIT_RST;
			rev_internal_limit_ff <= `STL_INT_LIMIT_RST;
			fwd_external_limit_ff <= `STL_EXT_LIMIT_RST;
			rev_external_limit_ff <= `STL_EXT_LIMIT_RST;
		end else if (wr_fire) begin
			if (aw_addr_ff == `STL_FWD_INT_OFS)
				fwd_internal_limit_ff <= clamp_pct(wr_val[15:0]);
			if (aw_addr_ff == `STL_REV_INT_OFS)
				rev_internal_limit_ff <= clamp_pct(wr_val[15:0]);
			if (aw_addr_ff == `STL_FWD_EXT_OFS)
				fwd_external_limit_ff <= clamp_pct(wr_val[15:0]);
			if (aw_addr_ff == `STL_REV_EXT_OFS)
				rev_external_limit_ff <= clamp_pct(wr_val[15:0]);
		end
	end

	// routing and mask registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			output_select_two_ff <= `STL_OUT_SEL_RST;
			other_out_ff <= 3'h0;
			irq_mask_ff <= 2'h0;
		end else if (wr_fire) begin
			if (aw_addr_ff == `STL_OUT_SEL_OFS)
				output_select_two_ff <= wr_val[15:0];
			if (aw_addr_ff == `STL_OUT_OTHER_OFS)
				other_out_ff <= wr_val[2:0];
			if (aw_addr_ff == `STL_IRQ_MASK_OFS)
				irq_mask_ff <= wr_val[1:0];
		end
	end

	// write response, okay or slverr
	always_ff @(posedge CLK) begin
		if (RST) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_ok ? 2'h0 : 2'h2;
		end else if (S_AXI_BREADY) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_BRESP = bresp_ff;

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	// read mux; monitor bits 6 and 7 carry the limit inputs
	always_comb begin
		rd_ok = 1'b1;
		rd_val = 32'h0;
		unique case (S_AXI_ARADDR[7:0])
			`STL_FWD_INT_OFS: rd_val = 32'(fwd_internal_limit_ff);
			`STL_REV_INT_OFS: rd_val = 32'(rev_internal_limit_ff);
			`STL_FWD_EXT_OFS: rd_val = 32'(fwd_external_limit_ff);
			`STL_REV_EXT_OFS: rd_val = 32'(rev_external_limit_ff);
			`STL_OUT_SEL_OFS: rd_val = 32'(output_select_two_ff);
			`STL_OUT_OTHER_OFS: rd_val = 32'(other_out_ff);
			`STL_TORQUE_OFS: rd_val = 32'(magnitude);
			`STL_STATUS_OFS: rd_val = {13'h0, fwd_ext_active, rev_ext_active, flag_ff,
				is_reverse ? rev_active : fwd_active};
			`STL_IRQ_STAT_OFS: rd_val = 32'(irq_stat_ff);
			`STL_IRQ_MASK_OFS: rd_val = 32'(irq_mask_ff);
			`STL_IN_MON_OFS: begin
				rd_val = 32'(pin_sync_ff[7:0]);
				rd_val[`STL_MON_FWD_BIT] = fwd_ext_active;
				rd_val[`STL_MON_REV_BIT] = rev_ext_active;
			end
			`STL_OUT_MON_OFS: rd_val = {29'h0, ~circ_n_ff}; // invert at 3 bits, not 32
			default: rd_ok = 1'b0;
		endcase
	end

	assign S_AXI_ARREADY = ~rvalid_ff;

	// read data registered one cycle after the address is taken
	always_ff @(posedge CLK) begin
		if (RST) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= 2'h0;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_val;
			rresp_ff <= rd_ok ? 2'h0 : 2'h2;
		end else if (S_AXI_RREADY) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign S_AXI_RVALID = rvalid_ff;
	assign S_AXI_RDATA = rdata_ff;
	assign S_AXI_RRESP = rresp_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	flag_sets_a: assert property (@(posedge CLK) disable iff (RST)
		(!is_reverse && magnitude > fwd_active) |=> flag_ff)
		else $error("flag not set above forward limit");
	flag_clears_a: assert property (@(posedge CLK) disable iff (RST)
		(!is_reverse && magnitude < fwd_active) |=> !flag_ff)
		else $error("flag set below forward limit");
	contact_low_a: assert property (@(posedge CLK) disable iff (RST)
		(nxt_flag && sel_field == 4'h1) |=> !OUT_CIRCUIT_N[0])
		else $error("circuit one not closed while flag routed");
	unrouted_open_a: assert property (@(posedge CLK) disable iff (RST)
		(sel_field == 4'h0 && other_out_ff == 3'h0) |=> OUT_CIRCUIT_N == 3'h7)
		else $error("contact closed with nothing routed");
	or_merge_a: assert property (@(posedge CLK) disable iff (RST)
		other_out_ff != 3'h0 |=> (OUT_CIRCUIT_N & $past(other_out_ff)) == 3'h0)
		else $error("other signal not ored onto its circuit");
	rev_own_limit_a: assert property (@(posedge CLK) disable iff (RST)
		(is_reverse && magnitude <= rev_active) |=> !flag_ff)
		else $error("reverse judged against wrong limit");
	fwd_ext_used_a: assert property (@(posedge CLK) disable iff (RST)
		(fwd_ext_active && fwd_external_limit_ff < fwd_internal_limit_ff)
		|-> fwd_active == fwd_external_limit_ff)
		else $error("forward external limit not applied");
	rev_ext_used_a: assert property (@(posedge CLK) disable iff (RST)
		(rev_ext_active && rev_external_limit_ff < rev_internal_limit_ff)
		|-> rev_active == rev_external_limit_ff)
		else $error("reverse external limit not applied");
	pin_polarity_a: assert property (@(posedge CLK) disable iff (RST)
		!FWD_EXT_LIMIT_IN_N |-> ##2 fwd_ext_active)
		else $error("low forward input not active");
	ext_idle_a: assert property (@(posedge CLK) disable iff (RST)
		!rev_ext_active |-> rev_active == rev_internal_limit_ff)
		else $error("reverse external limit applied while idle");
	ext_range_a: assert property (@(posedge CLK) disable iff (RST)
		fwd_external_limit_ff <= `STL_LIMIT_MAX)
		else $error("forward external limit out of range");
	int_range_a: assert property (@(posedge CLK) disable iff (RST)
		fwd_active <= fwd_internal_limit_ff && rev_active <= rev_internal_limit_ff)
		else $error("active limit above internal limit");
endmodule

/* File: stl_torque_limit_tb.sv */
// Purpose: self-checking bench for the torque-limit supervisor
// Assumes: register map and reset values of stl_map.svh
// Notes: each scenario is its own task; waits on handshakes are cut by the watchdog
`timescale 1ns/100ps
`include "stl_map.svh"
module stl_torque_limit_tb;
	// ----------------------------------------------------------------
	// stimulus and observation
	// ----------------------------------------------------------------
	logic clk = 1'h0, rst = 1'h1, fwd_req = 1'h0, rev_req = 1'h0;
	logic signed [15:0] tq = 16'sh0;
	logic [7:0] pins = 8'h1a;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic fwd_n, rev_n, flag, irq, awready, wready, bvalid, arready, rvalid;
	logic [2:0] out_n;
	logic [1:0] bresp, rresp;
	int failures = 0, checked = 0;

	always #5 clk = ~clk;

	stl_host_ctrl host (.clk(clk), .fwd_req(fwd_req), .rev_req(rev_req),
		.fwd_limit_n(fwd_n), .rev_limit_n(rev_n));

	stl_torque_limit uut (.CLK(clk), .RST(rst), .TORQUE_REF(tq), .FWD_EXT_LIMIT_IN_N(fwd_n),
		.REV_EXT_LIMIT_IN_N(rev_n), .INPUT_PINS(pins), .OUT_CIRCUIT_N(out_n),
		.TORQUE_LIMITED_FLAG(flag), .IRQ(irq), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_pins(input logic f, input logic [2:0] o);
		chk("flag", {31'h0, f}, {31'h0, flag});
		chk("out_n", {29'h0, o}, {29'h0, out_n});
	endtask

	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		logic ta, tw, da, dw;
		da = 1'h0;
		dw = 1'h0;
		@(posedge clk);
		awaddr <= {24'h0, a};
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(da && dw)) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge clk);
			if (ta) begin
				awvalid <= 1'h0;
				da = 1'h1;
			end
			if (tw) begin
				wvalid <= 1'h0;
				dw = 1'h1;
			end
		end
		bready <= 1'h1;
		do @(negedge clk); while (bvalid !== 1'h1);
		r = bresp;
		@(posedge clk);
		bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= {24'h0, a};
		arvalid <= 1'h1;
		do @(negedge clk); while (arready !== 1'h1);
		@(posedge clk);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(negedge clk); while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'h0;
	endtask

	// contact syncs need three edges; six leaves margin
	task automatic settle();
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic set_tq(input logic signed [15:0] v);
		@(posedge clk);
		tq <= v;
		settle();
	endtask

	task automatic set_ext(input logic f, input logic rv);
		@(posedge clk);
		fwd_req <= f;
		rev_req <= rv;
		settle();
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] ofs [5] = '{`STL_FWD_INT_OFS, `STL_REV_INT_OFS, `STL_FWD_EXT_OFS,
			`STL_REV_EXT_OFS, `STL_OUT_SEL_OFS};
		logic [15:0] rv [5] = '{16'h0320, 16'h0320, 16'h0064, 16'h0064, 16'h0000};
		logic [31:0] d;
		logic [1:0] r;
		chk_pins(1'h0, 3'h7);
		for (int i = 0; i < 5; i++) begin
			rd(ofs[i], d, r);
			chk("reset value", {16'h0, rv[i]}, d);
			chk("rresp", 32'h0, {30'h0, r});
		end
		rd(8'h30, d, r);
		chk("unmapped rresp", 32'h2, {30'h0, r});
		wr(8'h30, 32'h1, r);
		chk("unmapped bresp", 32'h2, {30'h0, r});
		chk("irq", 32'h0, {31'h0, irq});
	endtask

	// select codes 0 to 4, over and at the limit
	task automatic t_route();
		logic [1:0] r;
		for (int s = 0; s < 5; s++) begin
			wr(`STL_OUT_SEL_OFS, 32'(s), r);
			set_tq(16'sh0321);
			chk_pins(1'h1, (s >= 1 && s <= 3) ? ~(3'h1 << (s - 1)) : 3'h7);
			set_tq(16'sh0320);
			chk_pins(1'h0, 3'h7);
		end
	endtask

	task automatic t_or();
		logic [31:0] d;
		logic [1:0] r;
		wr(`STL_OUT_SEL_OFS, 32'h1, r);
		chk("bresp", 32'h0, {30'h0, r});
		wr(`STL_OUT_OTHER_OFS, 32'h2, r);
		set_tq(16'sh0);
		chk_pins(1'h0, 3'h5);
		set_tq(16'sh0321);
		chk_pins(1'h1, 3'h4);
		rd(`STL_OUT_MON_OFS, d, r);
		chk("out_mon", 32'h3, d);
		wr(`STL_OUT_OTHER_OFS, 32'h0, r);
	endtask

	task automatic t_ext();
		logic [31:0] d;
		logic [1:0] r;
		wr(`STL_OUT_SEL_OFS, 32'h2, r);
		set_ext(1'h1, 1'h0);
		rd(`STL_IN_MON_OFS, d, r);
		chk("in_mon", 32'h5a, d);
		set_tq(16'sh0065);
		chk_pins(1'h1, 3'h5);
		set_tq(16'sh0064);
		chk_pins(1'h0, 3'h7);
		set_tq(-16'sh0065);
		chk_pins(1'h0, 3'h7);
		rd(`STL_TORQUE_OFS, d, r);
		chk("torque", 32'h65, d);
		set_ext(1'h1, 1'h1);
		chk_pins(1'h1, 3'h5);
		rd(`STL_STATUS_OFS, d, r);
		chk("status", 32'h0007_0064, d);
		rd(`STL_IN_MON_OFS, d, r);
		chk("in_mon", 32'hda, d);
		set_ext(1'h0, 1'h0);
		chk_pins(1'h0, 3'h7);
	endtask

	task automatic t_min();
		logic [31:0] d;
		logic [1:0] r;
		wr(`STL_FWD_INT_OFS, 32'h32, r);
		set_tq(16'sh0033);
		chk_pins(1'h1, 3'h5);
		set_ext(1'h1, 1'h0);
		chk_pins(1'h1, 3'h5);
		wr(`STL_FWD_INT_OFS, 32'h320, r);
		wr(`STL_FWD_EXT_OFS, 32'h384, r);
		rd(`STL_FWD_EXT_OFS, d, r);
		chk("fwd_ext clamp", 32'h320, d);
		wr(`STL_FWD_EXT_OFS, 32'h28, r);
		settle();
		chk_pins(1'h1, 3'h5);
		set_ext(1'h0, 1'h0);
		chk_pins(1'h0, 3'h7);
		wr(`STL_FWD_EXT_OFS, 32'h64, r);
	endtask

	task automatic t_irq();
		logic [31:0] d;
		logic [1:0] r;
		set_tq(16'sh0);
		wr(`STL_IRQ_STAT_OFS, 32'h3, r);
		wr(`STL_IRQ_MASK_OFS, 32'h1, r);
		settle();
		chk("irq idle", 32'h0, {31'h0, irq});
		set_tq(16'sh0321);
		chk("irq rise", 32'h1, {31'h0, irq});
		rd(`STL_IRQ_STAT_OFS, d, r);
		chk("irq status", 32'h1, d);
		wr(`STL_IRQ_MASK_OFS, 32'h0, r);
		settle();
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`STL_IRQ_MASK_OFS, 32'h1, r);
		settle();
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(`STL_IRQ_STAT_OFS, 32'h1, r);
		settle();
		chk("irq cleared", 32'h0, {31'h0, irq});
		set_tq(16'sh0);
		chk("irq fall masked", 32'h0, {31'h0, irq});
		rd(`STL_IRQ_STAT_OFS, d, r);
		chk("irq status fall", 32'h2, d);
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		t_reset();
		t_route();
		t_or();
		t_ext();
		t_min();
		t_irq();
		complete_run();
	end

	// the sequence needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end
endmodule
